/* pmrm_pkg.sv */
// Constants for the power monitor result arithmetic block
package pmrm_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CYC_PER_US = (1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] ADDR_SETUP = 3'h0;
	localparam logic [2:0] ADDR_SHUNT = 3'h1;
	localparam logic [2:0] ADDR_SUPPLY = 3'h2;
	localparam logic [2:0] ADDR_POWER = 3'h3;
	localparam logic [2:0] ADDR_CURRENT = 3'h4;
	localparam logic [2:0] ADDR_SCALE = 3'h5;
	localparam logic [15:0] SETUP_RESET = 16'h4127;
	localparam logic [15:0] SCALE_RESET = 16'h0000;
	localparam int AVG_LSB = 9;
	localparam int SUP_CT_LSB = 6;
	localparam int SHUNT_CT_LSB = 3;
	localparam logic [13:0] CT_MIN_US = 14'd140;
	localparam logic [13:0] CT_MAX_US = 14'd8244;
	localparam int CURRENT_DIV = 2048;
	localparam int POWER_DIV = 20000;
	localparam int POWER_LSB_RATIO = 25;
	localparam int SUPPLY_LSB_UV = 1250;
	localparam int SUPPLY_MSB = 15;

	typedef enum logic [2:0] {
		S_START, S_SHUNT, S_CUR, S_SUP, S_PWR, S_LOAD
	} pmrm_state_e;

	// Conversion duration in microseconds for a 3-bit code
	function automatic logic [13:0] pmrm_ct_us(input logic [2:0] code);
		case (code)
			3'h0: pmrm_ct_us = CT_MIN_US;
			3'h1: pmrm_ct_us = 14'd204;
			3'h2: pmrm_ct_us = 14'd332;
			3'h3: pmrm_ct_us = 14'd588;
			3'h4: pmrm_ct_us = 14'd1100;
			3'h5: pmrm_ct_us = 14'd2116;
			3'h6: pmrm_ct_us = 14'd4156;
			default: pmrm_ct_us = CT_MAX_US;
		endcase
	endfunction

	// Averaging count as a power of two
	function automatic logic [3:0] pmrm_avg_shift(input logic [2:0] code);
		case (code)
			3'h0: pmrm_avg_shift = 4'h0;
			3'h1: pmrm_avg_shift = 4'h2;
			3'h2: pmrm_avg_shift = 4'h4;
			3'h3: pmrm_avg_shift = 4'h6;
			3'h4: pmrm_avg_shift = 4'h7;
			3'h5: pmrm_avg_shift = 4'h8;
			3'h6: pmrm_avg_shift = 4'h9;
			default: pmrm_avg_shift = 4'hA;
		endcase
	endfunction

	function automatic logic signed [25:0] pmrm_sx(input logic [15:0] v);
		pmrm_sx = {{10{v[15]}}, v};
	endfunction
endpackage

/* pmrm_top.sv */
// Measurement sequencing, averaging and current/power arithmetic
//
// Overview of operation
// - Each conversion lasts a selectable time between 140 us and 8.244 ms.
// - Shunt and supply conversions each take their own duration code.
// - Averaging count and both durations are fields of setup at 00h.
// - One power step is fixed at 25 current steps via the 20000 divisor.
// - Current is shunt value times scale factor divided by 2048.
// - Power is current value times supply value divided by 20000.
// - Current and power stay zero until a scale factor is written.
// - After a scale write, every newly loaded averaged set updates both results.
// - The supply result is the raw code at a fixed 1.25 mV weight.
// - The top bit of the supply result always reads as zero.
// - Current follows each shunt sample, power each supply sample.
// - Samples accumulate and only averages reach the result registers.
// - The ready flag sets once a whole averaged set is loaded.
`timescale 1ns/100ps
module pmrm_top
	import pmrm_pkg::*;
#(
	parameter int US_CYCLES = CYC_PER_US
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic ready_clear,
	input wire logic [15:0] adc_data,
	output logic [15:0] reg_rdata,
	output logic adc_start,
	output logic adc_supply_sel,
	output logic result_ready_flag
);
	////////////////////////////////////////////////////////////////////////
	pmrm_state_e state;
	logic [15:0] setup;
	logic [15:0] scale;
	logic cal_written;
	logic [15:0] shunt_r, supply_r, power_r, current_r;
	logic signed [15:0] shunt_s, sup_s, cur_s;
	logic signed [25:0] acc_shunt, acc_sup, acc_cur, acc_pwr;
	logic [10:0] n_samp;
	logic [15:0] pre;
	logic [13:0] remain;

	wire setup_wr = reg_wr && reg_addr == ADDR_SETUP;
	wire scale_wr = reg_wr && reg_addr == ADDR_SCALE;
	wire [3:0] avg_sh = pmrm_avg_shift(setup[AVG_LSB +: 3]);
	wire [13:0] shunt_ct = pmrm_ct_us(setup[SHUNT_CT_LSB +: 3]);
	wire [13:0] sup_ct = pmrm_ct_us(setup[SUP_CT_LSB +: 3]);
	wire conv_done = pre == 16'h0000 && remain == 14'h0000;
	wire [10:0] n_next = n_samp + 11'd1;
	wire last_samp = n_next == (11'd1 << avg_sh);

	// Truncating signed division, zero until calibrated
	wire signed [31:0] prod_cur = shunt_s * $signed(scale);
	wire signed [31:0] quot_cur = prod_cur / 32'(CURRENT_DIV);
	wire signed [31:0] prod_pwr = cur_s * sup_s;
	wire signed [31:0] quot_pwr = prod_pwr / 32'(POWER_DIV);
	wire signed [15:0] next_cur = cal_written ? quot_cur[15:0] : 16'sh0000;
	wire signed [15:0] next_pwr = cal_written ? quot_pwr[15:0] : 16'sh0000;
	wire [15:0] next_sup = {1'b0, adc_data[SUPPLY_MSB-1:0]};

	wire [25:0] avg_shunt = acc_shunt >>> avg_sh;
	wire [25:0] avg_sup = acc_sup >>> avg_sh;
	wire [25:0] avg_cur = acc_cur >>> avg_sh;
	wire [25:0] avg_pwr = acc_pwr >>> avg_sh;

	wire [15:0] next_rdata =
		reg_addr == ADDR_SETUP ? setup :
		reg_addr == ADDR_SHUNT ? shunt_r :
		reg_addr == ADDR_SUPPLY ? supply_r :
		reg_addr == ADDR_POWER ? power_r :
		reg_addr == ADDR_CURRENT ? current_r :
		reg_addr == ADDR_SCALE ? scale : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Register file
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			setup <= SETUP_RESET;
			scale <= SCALE_RESET;
			cal_written <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
			if (setup_wr) begin
				setup <= reg_wdata;
			end
			if (scale_wr) begin
				scale <= reg_wdata;
				cal_written <= 1'b1;
			end
		end
	end

	// Ready flag: setting wins over ready_clear in the same cycle, but a setup write clears it and wins over setting
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			result_ready_flag <= 1'b0;
		end else if (state == S_LOAD && !setup_wr) begin
			result_ready_flag <= 1'b1;
		end else if (setup_wr || ready_clear) begin
			result_ready_flag <= 1'b0;
		end
	end

	// Conversion timer in microsecond ticks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pre <= 16'h0000;
			remain <= 14'h0000;
		end else if (adc_start) begin
			pre <= 16'(US_CYCLES - 1);
			remain <= (adc_supply_sel ? sup_ct : shunt_ct) - 14'd1;
		end else if (pre == 16'h0000) begin
			pre <= conv_done ? 16'h0000 : 16'(US_CYCLES - 1);
			remain <= conv_done ? remain : remain - 14'd1;
		end else begin
			pre <= pre - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Measurement sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= S_START;
			adc_start <= 1'b0;
			adc_supply_sel <= 1'b0;
			shunt_s <= 16'sh0000;
			sup_s <= 16'sh0000;
			cur_s <= 16'sh0000;
			n_samp <= 11'h000;
			acc_shunt <= 26'sh0;
			acc_sup <= 26'sh0;
			acc_cur <= 26'sh0;
			acc_pwr <= 26'sh0;
			shunt_r <= 16'h0000;
			supply_r <= 16'h0000;
			current_r <= 16'h0000;
			power_r <= 16'h0000;
		end else begin
			adc_start <= 1'b0;
			if (setup_wr) begin
				state <= S_START;
				n_samp <= 11'h000;
				acc_shunt <= 26'sh0;
				acc_sup <= 26'sh0;
				acc_cur <= 26'sh0;
				acc_pwr <= 26'sh0;
			end else begin
				case (state)
					S_START: begin
						adc_start <= 1'b1;
						adc_supply_sel <= 1'b0;
						state <= S_SHUNT;
					end
					S_SHUNT: begin
						if (!adc_start && conv_done) begin
							shunt_s <= adc_data;
							state <= S_CUR;
						end
					end
					S_CUR: begin
						cur_s <= next_cur;
						acc_shunt <= acc_shunt + pmrm_sx(shunt_s);
						acc_cur <= acc_cur + pmrm_sx(next_cur);
						adc_start <= 1'b1;
						adc_supply_sel <= 1'b1;
						state <= S_SUP;
					end
					S_SUP: begin
						if (!adc_start && conv_done) begin
							sup_s <= next_sup;
							state <= S_PWR;
						end
					end
					S_PWR: begin
						acc_sup <= acc_sup + pmrm_sx(sup_s);
						acc_pwr <= acc_pwr + pmrm_sx(next_pwr);
						n_samp <= n_next;
						state <= last_samp ? S_LOAD : S_START;
					end
					S_LOAD: begin
						shunt_r <= avg_shunt[15:0];
						supply_r <= avg_sup[15:0];
						current_r <= avg_cur[15:0];
						power_r <= avg_pwr[15:0];
						n_samp <= 11'h000;
						acc_shunt <= 26'sh0;
						acc_sup <= 26'sh0;
						acc_cur <= 26'sh0;
						acc_pwr <= 26'sh0;
						state <= S_START;
					end
					default: state <= S_START;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	wire [31:0] ast_pc = prod_cur[31] ? 32'(-prod_cur) : prod_cur;
	wire [15:0] ast_cm = next_cur[15] ? 16'(-next_cur) : next_cur;
	wire [31:0] ast_qc = {5'h00, ast_cm, 11'h000};
	wire [31:0] ast_pp = prod_pwr[31] ? 32'(-prod_pwr) : prod_pwr;
	wire [15:0] ast_pm = next_pwr[15] ? 16'(-next_pwr) : next_pwr;
	wire [31:0] ast_qp = 32'(ast_pm) * 32'd20000;

	sequence seq_shunt_begin;
		state == S_CUR && !setup_wr;
	endsequence
	sequence seq_supply_began;
		adc_start && adc_supply_sel;
	endsequence

	AST_CT_RANGE: assert property (@(posedge mclk) disable iff (rst)
		shunt_ct >= CT_MIN_US && shunt_ct <= CT_MAX_US
		&& sup_ct >= CT_MIN_US && sup_ct <= CT_MAX_US)
		else $error("conversion duration out of range");
	AST_SEP_DUR: assert property (@(posedge mclk) disable iff (rst)
		seq_shunt_begin ##1 seq_supply_began |=>
		remain == $past(sup_ct) - 14'd1)
		else $error("supply conversion not timed by its own field");
	AST_SETUP_WR: assert property (@(posedge mclk) disable iff (rst)
		setup_wr |=> setup == $past(reg_wdata) && state == S_START)
		else $error("setup write not taken");
	AST_CUR_MATH: assert property (@(posedge mclk) disable iff (rst)
		state == S_CUR && cal_written && ast_pc < 32'h0400_0000 |->
		ast_pc >= ast_qc && ast_pc - ast_qc < 32'd2048)
		else $error("current quotient wrong");
	AST_PWR_MATH: assert property (@(posedge mclk) disable iff (rst)
		state == S_PWR && cal_written && ast_pp < 32'd655360000 |->
		ast_pp >= ast_qp && ast_pp - ast_qp < 32'd20000)
		else $error("power quotient wrong");
	AST_UNCAL_ZERO: assert property (@(posedge mclk) disable iff (rst)
		!cal_written |-> current_r == 16'h0000 && power_r == 16'h0000)
		else $error("result nonzero before calibration");
	AST_SUP_MSB: assert property (@(posedge mclk) disable iff (rst)
		!supply_r[15] && !sup_s[15])
		else $error("supply result top bit set");
	AST_BACKGROUND: assert property (@(posedge mclk) disable iff (rst)
		seq_shunt_begin |=> seq_supply_began)
		else $error("supply conversion delayed by arithmetic");
	AST_READY: assert property (@(posedge mclk) disable iff (rst)
		state == S_LOAD && !setup_wr |=> result_ready_flag
		&& current_r == $past(avg_cur[15:0]))
		else $error("ready flag or result load missing");
endmodule

/* pmrm_adc_model.sv */
// Converter stand-in answering shunt and supply conversions
`timescale 1ns/100ps
module pmrm_adc_model (
	input wire logic mclk,
	input wire logic adc_supply_sel,
	input wire logic [15:0] shunt_val,
	input wire logic [15:0] supply_val,
	output logic [15:0] adc_data
);
	// Raw supply code goes out with its top bit untouched
	always_ff @(posedge mclk) begin
		adc_data <= adc_supply_sel ? supply_val : shunt_val;
	end
endmodule

/* tb_top.sv */
// Self-checking bench for the result arithmetic block
`timescale 1ns/100ps
module tb_top;
	import pmrm_pkg::*;
	typedef struct {
		logic [15:0] scale, shunt, supply, cur, pwr, sup;
	} pmrm_row_s;
	logic mclk, rst, reg_wr, ready_clear;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, adc_data, shunt_val, supply_val;
	logic adc_start, adc_supply_sel, result_ready_flag;
	int err_count, n_tests;
	int ct_tab [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
	int tr [6][3] = '{'{0, 0, 7}, '{0, 7, 0}, '{1, 3, 3}, '{0, 1, 2},
		'{0, 4, 5}, '{0, 6, 6}};
	pmrm_row_s rows [5] = '{
		'{16'h0A00, 16'h1F40, 16'hA570, 16'h2710, 16'h12B8, 16'h2570},
		'{16'h0A00, 16'hE0C0, 16'h2570, 16'hD8F0, 16'hED48, 16'h2570},
		'{16'h0003, 16'hFC17, 16'h2570, 16'hFFFF, 16'h0000, 16'h2570},
		'{16'h03E8, 16'h1388, 16'h4E20, 16'h0989, 16'h0989, 16'h4E20},
		'{16'h0000, 16'h1F40, 16'h2570, 16'h0000, 16'h0000, 16'h2570}};

	pmrm_top #(.US_CYCLES(1)) pmrm_top_i (.mclk(mclk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.ready_clear(ready_clear), .adc_data(adc_data),
		.reg_rdata(reg_rdata), .adc_start(adc_start),
		.adc_supply_sel(adc_supply_sel),
		.result_ready_flag(result_ready_flag));
	pmrm_adc_model pmrm_adc_model_i (.mclk(mclk),
		.adc_supply_sel(adc_supply_sel), .shunt_val(shunt_val),
		.supply_val(supply_val), .adc_data(adc_data));

	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk16(string name, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_in(string name, int lo, int hi, int got);
		n_tests++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge mclk);
		reg_wr = 0;
	endtask
	task automatic rd(logic [2:0] a, output logic [15:0] v);
		@(negedge mclk);
		reg_addr = a;
		repeat (2) @(negedge mclk);
		v = reg_rdata;
	endtask
	// Bounded wait for a finished averaged set
	task automatic wait_flag(output int n);
		n = 0;
		while (result_ready_flag !== 1'b1) begin
			@(negedge mclk);
			n++;
			if (n > 40000) begin
				err_count++;
				$display("Error flag wait expected set seen clear");
				report_and_stop();
			end
		end
	endtask
	// Bounded wait for a conversion start of the given kind
	task automatic wait_adc(logic sel, output int k);
		k = 0;
		while (!(adc_start === 1'b1 && adc_supply_sel === sel)) begin
			@(negedge mclk);
			k++;
			if (k > 20000) begin
				err_count++;
				$display("Error conversion start expected pulse seen none");
				report_and_stop();
			end
		end
	endtask
	task automatic chk_res(logic [15:0] c, logic [15:0] p, logic [15:0] s);
		logic [15:0] v;
		rd(ADDR_CURRENT, v);
		chk16("current", c, v);
		rd(ADDR_POWER, v);
		chk16("power", p, v);
		rd(ADDR_SUPPLY, v);
		chk16("supply", s, v);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		int n, m, k;
		logic [15:0] v, s;
		rst = 1;
		reg_wr = 0;
		ready_clear = 0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		shunt_val = 16'h1F40;
		supply_val = 16'h2570;
		err_count = 0;
		n_tests = 0;
		repeat (8) @(negedge mclk);
		rst = 0;
		rd(ADDR_SETUP, v);
		chk16("setup reset", SETUP_RESET, v);
		rd(ADDR_SCALE, v);
		chk16("scale reset", SCALE_RESET, v);
		wr(ADDR_SETUP, 16'h4007);
		wait_flag(n);
		chk_res(16'h0000, 16'h0000, 16'h2570);
		// Scale 0A00h is 0.00512 over 1 mA steps times 2 mOhm
		foreach (rows[i]) begin
			shunt_val = rows[i].shunt;
			supply_val = rows[i].supply;
			wr(ADDR_SCALE, rows[i].scale);
			wr(ADDR_SETUP, 16'h4007);
			wait_flag(n);
			chk_res(rows[i].cur, rows[i].pwr, rows[i].sup);
		end
		// Read-only and unmapped places leave no trace
		wr(ADDR_CURRENT, 16'h1234);
		wr(3'h7, 16'hBEEF);
		chk_res(16'h0000, 16'h0000, 16'h2570);
		rd(3'h7, v);
		chk16("unmapped", 16'h0000, v);
		foreach (tr[i]) begin
			s = {4'h4, 3'(tr[i][0]), 3'(tr[i][1]), 3'(tr[i][2]), 3'h7};
			m = (tr[i][0] == 1) ? 4 : 1;
			n = ct_tab[tr[i][1]] + ct_tab[tr[i][2]];
			wr(ADDR_SETUP, s);
			wait_flag(k);
			chk_in("set time", m * n, m * (n + 6) + 6, k);
			rd(ADDR_SETUP, v);
			chk16("setup", s, v);
		end
		@(negedge mclk);
		ready_clear = 1;
		@(negedge mclk);
		ready_clear = 0;
		chk16("flag", 16'h0000, {15'h0, result_ready_flag});
		wait_flag(n);
		chk16("flag", 16'h0001, {15'h0, result_ready_flag});
		// Each conversion start follows its own duration field
		wr(ADDR_SETUP, 16'h408F);
		wait_adc(1'b0, k);
		wait_adc(1'b1, k);
		chk_in("shunt gap", 204, 208, k);
		wait_adc(1'b0, k);
		chk_in("supply gap", 332, 337, k);
		// Reset in mid-run restores the setup word
		rst = 1;
		repeat (2) @(negedge mclk);
		rst = 0;
		rd(ADDR_SETUP, v);
		chk16("setup after reset", SETUP_RESET, v);
		report_and_stop();
	end
endmodule
